// file: logic/rsbl_pkg.sv
// Package: constants and carrier types for the ROM/SRAM byte-lane interface.
package rsbl_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;

  // Region bases as byte addresses.
  localparam logic [23:0] SRAM_BASE = 24'hff0000;
  localparam logic [23:0] ROM_BASE = 24'hf80000;
  localparam logic [23:0] BOOT_BASE = 24'h000000;

  // Sizes in bytes across both lanes.
  localparam int SRAM_BYTES = 4096;
  localparam int ROM_32K = 32768;
  localparam int ROM_64K = 65536;
  localparam int ROM_128K = 131072;
  localparam int ROM_REGION_BYTES = 524288;
  localparam int RTC_LOCS = 8;

  // Acknowledge timing: three ticks of the fixed 8 MHz clock.
  localparam int CLK_MHZ = 250;
  localparam int SLOW_MHZ = 8;
  localparam int SLOW_DIV = CLK_MHZ / SLOW_MHZ;
  localparam int ACK_TICKS = 3;

  typedef enum logic [1:0] {
    RSBL_ROM_32K = 2'h0,
    RSBL_ROM_64K = 2'h1,
    RSBL_ROM_128K = 2'h2
  } rsbl_rom_size_t;

  // Processor bus request as seen by the block.
  typedef struct packed {
    logic as_n;
    logic uds_n;
    logic lds_n;
    logic rw;
    logic [23:1] addr;
    logic [15:0] wdata;
  } rsbl_bus_req_t;

  // Control for one byte-wide memory chip.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } rsbl_chip_ctl_t;

endpackage : rsbl_pkg

// file: logic/rsbl_mem.sv
// Byte-wide memory chip model with one registered read port.
module rsbl_mem #(
  parameter int DEPTH = 2048,
  parameter int AW = 11
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_q[i_addr] <= i_wdata;
    end
    if (i_ce) begin
      rdata_q <= mem_q[i_addr];
    end
  end

  assign o_rdata = rdata_q;

endmodule : rsbl_mem

// file: logic/rsbl_top.sv
// Top of the ROM/SRAM byte-lane interface: decode, lane steering, chip controls and acknowledge.
//
// Behaviour
// - Upper-byte chips sit on data bits 15..8, lower-byte chips on bits 7..0.
// - Even byte addresses go to the upper chip, odd to the lower chip.
// - Chip address input 0 comes from bus address line 1, and upward.
// - The static RAM region starts at byte address ff0000.
// - Program memory answers from byte address f80000 upward.
// - Both program chips share one chip enable and one output enable.
// - Static RAM has one enable per lane so writes spare the other lane.
// - Chip enable and output enable rise and fall together on reads; RAM writes keep output enable high.
// - Read data reach the bus only while output enable is asserted.
// - Program memory is sized 32K, 64K or 128K by two jumpers.
// - Boot jumper in position 2 also maps program memory at address 0.
// - Static RAM holds 4K bytes across two byte-wide chips.
// - A clock chip in the lower lane replaces its top 8 locations.
// - Acknowledge asserts on the third fixed 8 MHz clock tick after select, two to three periods later.
module rsbl_top #(
  parameter int SRAM_BYTES = rsbl_pkg::SRAM_BYTES,
  parameter int ROM_MAX_BYTES = rsbl_pkg::ROM_128K,
  parameter int ACK_TICKS = rsbl_pkg::ACK_TICKS,
  parameter int SLOW_DIV = rsbl_pkg::SLOW_DIV
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire rsbl_pkg::rsbl_bus_req_t I_BUS,
  input wire logic I_BOOT_MAP_JUMPER,
  input wire logic I_ROM_SIZE_JUMPER_A,
  input wire logic I_ROM_SIZE_JUMPER_B,
  input wire logic I_RTC_FITTED,
  input wire logic [7:0] I_RTC_RDATA,
  output logic [15:0] O_RDATA,
  output logic O_RDATA_OE,
  output logic O_TRANSFER_ACKNOWLEDGE_LOW,
  output rsbl_pkg::rsbl_chip_ctl_t O_ROM_CTL,
  output rsbl_pkg::rsbl_chip_ctl_t O_SRAM_HI_CTL,
  output rsbl_pkg::rsbl_chip_ctl_t O_SRAM_LO_CTL,
  output logic O_RTC_SEL,
  output logic [2:0] O_RTC_ADDR,
  output logic [7:0] O_RTC_WDATA,
  output logic O_RTC_WE
);

  localparam int SRAM_LOCS = SRAM_BYTES / 2;
  localparam int SRAM_AW = $clog2(SRAM_LOCS);
  localparam int ROM_LOCS = ROM_MAX_BYTES / 2;
  localparam int ROM_AW = $clog2(ROM_LOCS);
  localparam int DIV_W = $clog2(SLOW_DIV + 1);
  localparam logic [2:0] TICK_LAST = 3'(ACK_TICKS);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

  typedef enum logic [1:0] {
    RSBL_IDLE = 2'b00,
    RSBL_WAIT = 2'b01,
    RSBL_ACK = 2'b11
  } rsbl_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // True when a byte address falls in a power-of-two region aligned at its base.
  function automatic logic in_region(input logic [23:0] addr, input logic [23:0] base,
                                     input int bytes);
    logic [23:0] mask;
    mask = ~(24'(bytes) - 24'h000001);
    in_region = ((addr & mask) == (base & mask));
  endfunction : in_region

  logic [23:0] byte_addr;
  rsbl_pkg::rsbl_rom_size_t rom_size;
  int rom_bytes;
  logic rom_hit;
  logic sram_hit;
  logic rtc_hit;
  logic [ROM_AW-1:0] rom_loc;
  logic [SRAM_AW-1:0] sram_loc;

  always_comb begin
    byte_addr = {I_BUS.addr, 1'b0};
    // Jumper code: a=2,b=1 small; a=2,b=2 middle; a=1,b=2 large (high = position 2).
    rom_size = rsbl_pkg::RSBL_ROM_128K;
    if (I_ROM_SIZE_JUMPER_A) begin
      rom_size = I_ROM_SIZE_JUMPER_B ? rsbl_pkg::RSBL_ROM_64K : rsbl_pkg::RSBL_ROM_32K;
    end
    unique case (rom_size)
      rsbl_pkg::RSBL_ROM_32K: rom_bytes = rsbl_pkg::ROM_32K;
      rsbl_pkg::RSBL_ROM_64K: rom_bytes = rsbl_pkg::ROM_64K;
      default: rom_bytes = rsbl_pkg::ROM_128K;
    endcase
    // The region itself spans 512K; smaller parts just repeat through it.
    // The RAM window lies inside it and wins there, so a RAM read never wakes the ROM pair.
    rom_hit = (in_region(byte_addr, rsbl_pkg::ROM_BASE, rsbl_pkg::ROM_REGION_BYTES)
      && !in_region(byte_addr, rsbl_pkg::SRAM_BASE, SRAM_BYTES))
      || (I_BOOT_MAP_JUMPER && in_region(byte_addr, rsbl_pkg::BOOT_BASE, rom_bytes));
    rom_hit = rom_hit && !I_BUS.as_n && I_BUS.rw;
    sram_hit = in_region(byte_addr, rsbl_pkg::SRAM_BASE, SRAM_BYTES) && !I_BUS.as_n;
    // Word location is the byte address divided by two; the jumpers cut unused lines.
    rom_loc = I_BUS.addr[ROM_AW:1] & ROM_AW'(rom_bytes / 2 - 1);
    sram_loc = I_BUS.addr[SRAM_AW:1];
    // Only the lower lane goes to the clock chip; the upper lane there stays plain RAM.
    rtc_hit = I_RTC_FITTED && (sram_loc >= SRAM_AW'(SRAM_LOCS - rsbl_pkg::RTC_LOCS));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip controls and acknowledge timing.

  rsbl_state_t state_q, state_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [2:0] tick_q, tick_d;
  logic slow_en;
  logic rom_sel_q, rom_sel_d;
  logic sram_hi_q, sram_hi_d;
  logic sram_lo_q, sram_lo_d;
  logic rtc_sel_q, rtc_sel_d;
  logic we_q, we_d;
  logic ack_q, ack_d;
  logic [SRAM_AW-1:0] sram_loc_q, sram_loc_d;
  logic [ROM_AW-1:0] rom_loc_q, rom_loc_d;
  logic [15:0] wdata_q, wdata_d;

  always_comb begin
    slow_en = (div_q == DIV_LAST);
    div_d = slow_en ? '0 : div_q + DIV_W'(1);
    state_d = state_q;
    tick_d = tick_q;
    rom_sel_d = rom_sel_q;
    sram_hi_d = sram_hi_q;
    sram_lo_d = sram_lo_q;
    rtc_sel_d = rtc_sel_q;
    we_d = we_q;
    ack_d = ack_q;
    sram_loc_d = sram_loc_q;
    rom_loc_d = rom_loc_q;
    wdata_d = wdata_q;
    unique case (state_q)
      RSBL_IDLE: begin
        if (rom_hit || sram_hit) begin
          state_d = RSBL_WAIT;
          tick_d = '0;
          rom_sel_d = rom_hit;
          // Even address is the upper strobe, odd the lower one.
          sram_hi_d = sram_hit && !I_BUS.uds_n;
          sram_lo_d = sram_hit && !I_BUS.lds_n && !rtc_hit;
          rtc_sel_d = sram_hit && !I_BUS.lds_n && rtc_hit;
          we_d = sram_hit && !I_BUS.rw;
          sram_loc_d = sram_loc;
          rom_loc_d = rom_loc;
          wdata_d = I_BUS.wdata;
        end
      end
      RSBL_WAIT: begin
        // The delay counts slow-clock edges, so a faster processor clock does not shorten it.
        // The slow divider runs free, so the wait varies by up to one slow period.
        if (slow_en) begin
          tick_d = tick_q + 3'h1;
          if (tick_q + 3'h1 == TICK_LAST) begin
            state_d = RSBL_ACK;
            ack_d = 1'b1;
          end
        end
        // A strobe that rises early abandons the access, and nothing is acknowledged.
        if (I_BUS.as_n) begin
          state_d = RSBL_IDLE;
        end
      end
      RSBL_ACK: begin
        if (I_BUS.as_n) begin
          state_d = RSBL_IDLE;
        end
      end
      default: state_d = RSBL_IDLE;
    endcase
    if (state_d == RSBL_IDLE) begin
      // Enables drop with the strobe so the chips fall back to standby.
      rom_sel_d = 1'b0;
      sram_hi_d = 1'b0;
      sram_lo_d = 1'b0;
      rtc_sel_d = 1'b0;
      we_d = 1'b0;
      ack_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state_q <= RSBL_IDLE;
      div_q <= '0;
      tick_q <= '0;
      rom_sel_q <= 1'b0;
      sram_hi_q <= 1'b0;
      sram_lo_q <= 1'b0;
      rtc_sel_q <= 1'b0;
      we_q <= 1'b0;
      ack_q <= 1'b0;
      sram_loc_q <= '0;
      rom_loc_q <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      div_q <= div_d;
      tick_q <= tick_d;
      rom_sel_q <= rom_sel_d;
      sram_hi_q <= sram_hi_d;
      sram_lo_q <= sram_lo_d;
      rtc_sel_q <= rtc_sel_d;
      we_q <= we_d;
      ack_q <= ack_d;
      sram_loc_q <= sram_loc_d;
      rom_loc_q <= rom_loc_d;
      wdata_q <= wdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory chips: one pair per region, each chip on its own byte lane.

  logic [7:0] rom_rd [2];
  logic [7:0] sram_rd [2];
  logic [1:0] sram_ce;

  assign sram_ce = {sram_hi_q, sram_lo_q};

  // Lane 1 is the upper byte on bits 15..8, lane 0 the lower byte on bits 7..0.
  // The program pair is never written from the bus; its contents are loaded outside this block.
  for (genvar g = 0; g < 2; g++) begin : g_lane
    rsbl_mem #(.DEPTH(ROM_LOCS), .AW(ROM_AW)) u_rom (
      .i_clk(I_CLK),
      .i_ce(rom_sel_q),
      .i_we(1'b0),
      .i_addr(rom_loc_q),
      .i_wdata(8'h00),
      .o_rdata(rom_rd[g])
    );
    rsbl_mem #(.DEPTH(SRAM_LOCS), .AW(SRAM_AW)) u_sram (
      .i_clk(I_CLK),
      .i_ce(sram_ce[g]),
      .i_we(we_q),
      .i_addr(sram_loc_q),
      .i_wdata(wdata_q[g*8 +: 8]),
      .o_rdata(sram_rd[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: data drive and strobes.

  logic [15:0] rdata_d;
  logic oe_d;
  rsbl_pkg::rsbl_chip_ctl_t rom_ctl_d, hi_ctl_d, lo_ctl_d;

  // Strobes of one RAM chip: output enable only on reads, write enable only on writes.
  function automatic rsbl_pkg::rsbl_chip_ctl_t ram_ctl(input logic en, input logic wr);
    ram_ctl.ce_n = !en;
    ram_ctl.oe_n = !(en && !wr);
    ram_ctl.we_n = !(en && wr);
  endfunction : ram_ctl

  always_comb begin
    // Output enable rises with the acknowledge on reads; reads drive the bus only with it.
    oe_d = ack_d && !we_d && (rom_sel_d || sram_hi_d || sram_lo_d || rtc_sel_d);
    rdata_d = '0;
    if (oe_d) begin
      if (rom_sel_q) begin
        // Both lanes drive; a byte read simply ignores the other half.
        rdata_d = {rom_rd[1], rom_rd[0]};
      end else begin
        rdata_d[15:8] = sram_hi_q ? sram_rd[1] : 8'h00;
        rdata_d[7:0] = rtc_sel_q ? I_RTC_RDATA : (sram_lo_q ? sram_rd[0] : 8'h00);
      end
    end
    rom_ctl_d = '{ce_n: !rom_sel_d, oe_n: !rom_sel_d, we_n: 1'b1};
    hi_ctl_d = ram_ctl(sram_hi_d, we_d);
    lo_ctl_d = ram_ctl(sram_lo_d, we_d);
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      // Inactive levels from the first edge keep every chip in standby.
      O_RDATA <= '0;
      O_RDATA_OE <= 1'b0;
      O_TRANSFER_ACKNOWLEDGE_LOW <= 1'b1;
      O_ROM_CTL <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      O_SRAM_HI_CTL <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      O_SRAM_LO_CTL <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      O_RTC_SEL <= 1'b0;
      O_RTC_ADDR <= '0;
      O_RTC_WDATA <= '0;
      O_RTC_WE <= 1'b0;
    end else begin
      O_RDATA <= rdata_d;
      O_RDATA_OE <= oe_d;
      O_TRANSFER_ACKNOWLEDGE_LOW <= !ack_d;
      O_ROM_CTL <= rom_ctl_d;
      O_SRAM_HI_CTL <= hi_ctl_d;
      O_SRAM_LO_CTL <= lo_ctl_d;
      O_RTC_SEL <= rtc_sel_d;
      O_RTC_ADDR <= sram_loc_d[2:0];
      O_RTC_WDATA <= wdata_d[7:0];
      O_RTC_WE <= rtc_sel_d && we_d;
    end
  end

endmodule : rsbl_top

// file: sim/rsbl_top_assertions.sv
// Port-level checks for the ROM/SRAM byte-lane interface.
module rsbl_top_assertions #(
  parameter int ACK_TICKS = 3,
  parameter int SLOW_DIV = 31
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire rsbl_pkg::rsbl_bus_req_t I_BUS,
  input wire logic [15:0] O_RDATA,
  input wire logic O_RDATA_OE,
  input wire logic O_TRANSFER_ACKNOWLEDGE_LOW,
  input wire rsbl_pkg::rsbl_chip_ctl_t O_ROM_CTL,
  input wire rsbl_pkg::rsbl_chip_ctl_t O_SRAM_HI_CTL,
  input wire rsbl_pkg::rsbl_chip_ctl_t O_SRAM_LO_CTL,
  input wire logic O_RTC_SEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  logic sel;
  logic [15:0] wait_q;
  logic [15:0] wait_d;
  assign sel = !O_ROM_CTL.ce_n || !O_SRAM_HI_CTL.ce_n || !O_SRAM_LO_CTL.ce_n || O_RTC_SEL;
  // The slow divider runs free, so the first tick may come at any phase.
  always_comb begin
    wait_d = (sel && O_TRANSFER_ACKNOWLEDGE_LOW) ? wait_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge I_CLK) begin
    wait_q <= I_SRST ? 16'h0 : wait_d;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_rom_shared_en: assert property (O_ROM_CTL.we_n && O_ROM_CTL.ce_n == O_ROM_CTL.oe_n)
    else $error("program chip enables split or written");
  chk_sram_one_op: assert property (!O_SRAM_HI_CTL.ce_n |-> O_SRAM_HI_CTL.oe_n != O_SRAM_HI_CTL.we_n)
    else $error("upper RAM chip enabled without exactly one of read or write");
  chk_we_follows_rw: assert property ($fell(O_SRAM_HI_CTL.ce_n) |-> O_SRAM_HI_CTL.we_n == $past(I_BUS.rw))
    else $error("RAM write enable differs from read/write line");
  chk_lower_lane: assert property ($fell(O_SRAM_LO_CTL.ce_n) |-> !$past(I_BUS.lds_n))
    else $error("lower RAM enabled without lower strobe");
  chk_rdata_quiet: assert property (!O_RDATA_OE |-> O_RDATA == 16'h0)
    else $error("read data present without output enable");
  chk_ack_delay: assert property ($fell(O_TRANSFER_ACKNOWLEDGE_LOW) |->
    wait_q >= (ACK_TICKS - 1) * SLOW_DIV && wait_q <= ACK_TICKS * SLOW_DIV + 2)
    else $error("acknowledge delay out of range");
  chk_ack_needs_sel: assert property (!O_TRANSFER_ACKNOWLEDGE_LOW |-> sel)
    else $error("acknowledge without a selected memory");
  chk_release_all: assert property ($rose(I_BUS.as_n) |-> ##2 (!sel && O_TRANSFER_ACKNOWLEDGE_LOW))
    else $error("enables or acknowledge not released after strobe");
  chk_sram_take: assert property ($fell(I_BUS.as_n) && I_BUS.addr[23:12] == 12'hff0 && !I_BUS.uds_n
    |-> ##[1:2] !O_SRAM_HI_CTL.ce_n)
    else $error("RAM region access not selected");
endmodule : rsbl_top_assertions

// file: sim/rsbl_bus_master.sv
// Behavioural processor bus master running one strobed transfer at a time.
module rsbl_bus_master (
  input wire logic i_clk,
  input wire logic i_ack_n,
  input wire logic [15:0] i_rdata,
  output rsbl_pkg::rsbl_bus_req_t o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_bus = '{as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
  // A missing acknowledge ends the cycle after 40 clocks, as a bus error would.
  task automatic xfer(input logic [23:0] a, input logic rw, input logic [15:0] wd,
                      input logic [1:0] lanes, output logic [15:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 16'h0;
    @(posedge i_clk);
    o_bus <= '{as_n: 1'b0, uds_n: !lanes[1], lds_n: !lanes[0], rw: rw, addr: a[23:1], wdata: wd};
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge i_clk);
      ok = !i_ack_n;
    end
    rd = i_rdata & {{8{lanes[1]}}, {8{lanes[0]}}};
    o_bus <= '{as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1, rw: 1'b1, addr: ~o_bus.addr,
               wdata: ~o_bus.wdata};
    repeat (3) @(posedge i_clk);
  endtask : xfer
endmodule : rsbl_bus_master

// file: sim/tb_rom_sram_byte_lane_interface.sv
// Self-checking bench for the ROM/SRAM byte-lane interface.
module tb_rom_sram_byte_lane_interface;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW_DIV = 2;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic boot = 1'b1;
  logic sz_a = 1'b1;
  logic sz_b = 1'b0;
  logic rom_seen = 1'b0;
  logic rtc = 1'b0;
  rsbl_pkg::rsbl_bus_req_t bus;
  logic [15:0] rdata;
  logic oe;
  logic ack_n;
  rsbl_pkg::rsbl_chip_ctl_t rom_ctl;
  rsbl_pkg::rsbl_chip_ctl_t hi_ctl;
  rsbl_pkg::rsbl_chip_ctl_t lo_ctl;
  logic [15:0] rd;
  logic rtc_sel;
  logic [2:0] rtc_addr;
  logic [7:0] rtc_wdata;
  logic rtc_we;
  logic [11:0] rtc_cap = 12'h000;
  logic oe_at_ack = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (!rom_ctl.ce_n) rom_seen <= 1'b1;
  always @(posedge clk) if (rtc_sel) rtc_cap <= {rtc_we, rtc_addr, rtc_wdata};
  always @(posedge clk) if (!ack_n) oe_at_ack <= oe;
  rsbl_top #(.SLOW_DIV(SLOW_DIV)) dut_u (.I_CLK(clk), .I_SRST(srst), .I_BUS(bus),
    .I_BOOT_MAP_JUMPER(boot), .I_ROM_SIZE_JUMPER_A(sz_a), .I_ROM_SIZE_JUMPER_B(sz_b),
    .I_RTC_FITTED(rtc), .I_RTC_RDATA(8'hc3), .O_RDATA(rdata), .O_RDATA_OE(oe),
    .O_TRANSFER_ACKNOWLEDGE_LOW(ack_n), .O_ROM_CTL(rom_ctl), .O_SRAM_HI_CTL(hi_ctl),
    .O_SRAM_LO_CTL(lo_ctl), .O_RTC_SEL(rtc_sel), .O_RTC_ADDR(rtc_addr),
    .O_RTC_WDATA(rtc_wdata), .O_RTC_WE(rtc_we));
  rsbl_bus_master master_u (.i_clk(clk), .i_ack_n(ack_n), .i_rdata(rdata), .o_bus(bus));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // A missing acknowledge that was expected ends the run at once.
  task automatic acc(input logic [23:0] a, input logic rw, input logic [15:0] wd,
                     input logic [1:0] lanes, input logic exp_ok);
    logic ok;
    master_u.xfer(a, rw, wd, lanes, rd, ok);
    check({15'h0, ok}, {15'h0, exp_ok});
    if (exp_ok && !ok) conclude();
  endtask : acc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({6'h0, rom_ctl, hi_ctl, lo_ctl, ack_n}, 16'h03ff); // RESET
    check(rdata, 16'h0000); // RESET
    check({2'h0, oe, rtc_sel, rtc_we, rtc_addr, rtc_wdata}, 16'h0000); // RESET
  endtask : t_reset
  task automatic t_sram();
    acc(24'hff0000, 1'b0, 16'h1234, 2'b11, 1'b1);
    check({15'h0, oe_at_ack}, 16'h0000);
    acc(24'hff0003, 1'b0, 16'h55ab, 2'b01, 1'b1);
    acc(24'hff0002, 1'b0, 16'hcd77, 2'b10, 1'b1);
    acc(24'hff0ffe, 1'b0, 16'h5a5a, 2'b11, 1'b1);
    rom_seen = 1'b0;
    acc(24'hff0002, 1'b1, 16'h0000, 2'b11, 1'b1);
    check(rd, 16'hcdab);
    check({15'h0, oe_at_ack}, 16'h0001);
    acc(24'hff0000, 1'b1, 16'h0000, 2'b11, 1'b1);
    check(rd, 16'h1234);
    acc(24'hff0ffe, 1'b1, 16'h0000, 2'b11, 1'b1);
    check(rd, 16'h5a5a);
    acc(24'hff0001, 1'b1, 16'h0000, 2'b01, 1'b1);
    check(rd, 16'h0034);
    check({15'h0, rom_seen}, 16'h0000);
  endtask : t_sram
  task automatic t_rtc();
    @(posedge clk);
    rtc <= 1'b1;
    acc(24'hff0ffe, 1'b1, 16'h0000, 2'b11, 1'b1);
    check(rd, 16'h5ac3);
    acc(24'hff0ff9, 1'b0, 16'h0096, 2'b01, 1'b1);
    check({4'h0, rtc_cap}, 16'h0c96);
    @(posedge clk);
    rtc <= 1'b0;
    acc(24'hff0ffe, 1'b1, 16'h0000, 2'b11, 1'b1);
    check(rd, 16'h5a5a);
  endtask : t_rtc
  task automatic t_rom();
    int i;
    int size;
    for (i = 0; i < 3; i++) begin
      size = 32768 << i;
      @(posedge clk);
      sz_a <= (i != 2);
      sz_b <= (i != 0);
      rom_seen = 1'b0;
      acc(size - 2, 1'b1, 16'h0000, 2'b11, 1'b1);
      check({15'h0, rom_seen}, 16'h0001);
      acc(size, 1'b1, 16'h0000, 2'b11, 1'b0);
    end
    rom_seen = 1'b0;
    acc(24'hf80000, 1'b1, 16'h0000, 2'b10, 1'b1);
    check({15'h0, rom_seen}, 16'h0001);
    acc(24'hf80000, 1'b0, 16'hffff, 2'b11, 1'b0);
    @(posedge clk);
    boot <= 1'b0;
    acc(24'h000000, 1'b1, 16'h0000, 2'b11, 1'b0);
    acc(24'h100000, 1'b1, 16'h0000, 2'b11, 1'b0);
  endtask : t_rom
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_sram();
    t_rtc();
    t_rom();
    conclude();
  end
endmodule : tb_rom_sram_byte_lane_interface

bind rsbl_top rsbl_top_assertions #(.ACK_TICKS(ACK_TICKS), .SLOW_DIV(SLOW_DIV)) chk_u (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_BUS(I_BUS), .O_RDATA(O_RDATA), .O_RDATA_OE(O_RDATA_OE),
  .O_TRANSFER_ACKNOWLEDGE_LOW(O_TRANSFER_ACKNOWLEDGE_LOW), .O_ROM_CTL(O_ROM_CTL),
  .O_SRAM_HI_CTL(O_SRAM_HI_CTL), .O_SRAM_LO_CTL(O_SRAM_LO_CTL), .O_RTC_SEL(O_RTC_SEL));
